/* ngm_regs.sv */
// Register bank: noise gate, supply switch thresholds, pin pull-downs and interrupt masks.
// Assumes a single AXI4-Lite master, one clock, synchronous active-low reset.
// ============================================================================
// Summary of operation
// - Entry delay code in bits 7..5 selects 400us to 1s, reset code 5.
// - Level threshold code in bits 4..3 selects -90 to -120 dBFS, reset 3.
// - Gate enabled while bit 2 is one; resets to one.
// - Volume ramp bit zero ramps, one skips; resets to one.
// - Supply hysteresis codes A..F valid, 0..9 reserved, reset D.
// - Threshold mode bit 7: zero fixed, one relative; resets to one.
// - Fixed threshold 5-bit code in quarter-dB steps, reset 08h.
// - Pull-down enables bits 6..2 for five pins, all reset to zero.
// - Register 3Bh bits 7 and 6 mask brown-out mute and hold.
// - Register 3Ch bit 6 fuse CRC mask, bit 0 limiter mask.
// - Register 3Dh bit 7 masks derived clock error.
// - Register 40h bits 7..4 mask temperature causes, reset masked.
// - Register 40h bit 3 regulator, bit 0 high supply undervoltage masks.
// - Register 41h bits 7..5 thermal and supply difference masks, reset unmasked.
// - Register 41h bits 4..2 brown-out masks with listed reset values.
// - Latched read-only cause flags from 42h upward, cleared by reading.
module ngm_regs
  import ngm_pkg::*;
#(
  parameter int DELAY_MAX_CYCLES = CLK_MHZ * 1000000
) (
  // Clock and reset.
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  // AXI4-Lite write address and data.
  input wire logic I_AWVALID,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  output logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_WREADY,
  // AXI4-Lite write response.
  output logic O_BVALID,
  output logic [1:0] O_BRESP,
  input wire logic I_BREADY,
  // AXI4-Lite read.
  input wire logic I_ARVALID,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  output logic O_ARREADY,
  output logic O_RVALID,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_RREADY,
  // Interrupt causes from the amplifier core, one-cycle pulses.
  input wire logic [7:0] I_CAUSE_A,
  input wire logic [7:0] I_CAUSE_B,
  input wire logic [7:0] I_CAUSE_C,
  input wire logic [7:0] I_CAUSE_D,
  input wire logic [7:0] I_CAUSE_E,
  // Configuration to the amplifier core.
  output logic [2:0] O_GATE_ENTRY_DELAY,
  output logic [31:0] O_GATE_ENTRY_CYCLES,
  output logic [1:0] O_GATE_LEVEL_THRESHOLD,
  output logic O_GATE_ENABLE,
  output logic O_GATE_VOLUME_RAMP_OFF,
  output logic [3:0] O_SUPPLY_SWITCH_HYSTERESIS,
  output logic O_SUPPLY_SWITCH_HYST_VALID,
  output logic O_SUPPLY_SWITCH_THRESHOLD_MODE,
  output logic [4:0] O_SUPPLY_SWITCH_FIXED_THRESHOLD,
  output logic [4:0] O_PIN_WEAK_PULLDOWN,
  // Interrupt line.
  output logic O_IRQ
);
  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    ngm_bus_t bus;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NUM_REGS-1:0][7:0] regs;
    logic [31:0] delay_cycles;
    logic supply_valid;
    logic irq;
  } ngm_state_t;

  ngm_state_t st;
  ngm_state_t next_st;
  logic [NUM_FLAGS-1:0][7:0] flags;
  logic [NUM_FLAGS-1:0][7:0] masks;
  logic [NUM_FLAGS-1:0][7:0] causes;
  logic [NUM_FLAGS-1:0] pending;
  logic [NUM_FLAGS-1:0] read_clear;
  logic [7:0] rd_idx;
  logic [7:0] wr_idx;

  localparam logic [7:0] REG_IDX [NUM_REGS] = '{IDX_GATE_CFG, IDX_RAMP_HYS, IDX_SW_THR, IDX_PULLDOWN,
    IDX_MASK_BOH, IDX_MASK_CRC, IDX_MASK_CLK, IDX_MASK_TMP, IDX_MASK_THB};
  localparam logic [7:0] REG_RST [NUM_REGS] = '{RST_GATE_CFG, RST_RAMP_HYS, RST_SW_THR, RST_PULLDOWN,
    RST_MASK_BOH, RST_MASK_CRC, RST_MASK_CLK, RST_MASK_TMP, RST_MASK_THB};
  localparam logic [7:0] REG_WR [NUM_REGS] = '{WR_GATE_CFG, WR_RAMP_HYS, WR_SW_THR, WR_PULLDOWN,
    WR_MASK_BOH, WR_MASK_CRC, WR_MASK_CLK, WR_MASK_TMP, WR_MASK_THB};
  localparam logic [7:0] FLAG_IDX [NUM_FLAGS] = '{IDX_FLAG_A, IDX_FLAG_B, IDX_FLAG_C, IDX_FLAG_D, IDX_FLAG_E};
  localparam logic [7:0] FLAG_USED [NUM_FLAGS] = '{FL_USED_A, FL_USED_B, FL_USED_C, FL_USED_D, FL_USED_E};
  localparam int REG_GATE = 0;
  localparam int REG_RAMP = 1;
  localparam int REG_THR = 2;
  localparam int REG_PD = 3;

  // Word address: the printed offsets are indices, so the byte address is four times the index.
  assign rd_idx = I_ARADDR[ADDR_W-1:2];
  assign wr_idx = st.waddr[ADDR_W-1:2];

  // Mask registers line up with the flag registers they gate.
  assign masks = {st.regs[8], st.regs[7], st.regs[6], st.regs[5], st.regs[4]};
  assign causes = {I_CAUSE_E, I_CAUSE_D, I_CAUSE_C, I_CAUSE_B, I_CAUSE_A};

  // ==========================================================================
  // Flag registers, one instance per latched cause register
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < NUM_FLAGS; g++) begin : g_flag
      // Clear only when the read is really taken; a pending complete write has priority.
      assign read_clear[g] = (st.bus == NGM_IDLE) && !(st.aw_got && st.w_got) && I_ARVALID &&
        (rd_idx == FLAG_IDX[g]);
      ngm_flag #(.USED(FLAG_USED[g])) u_flag (
        .i_clk(I_CLOCK),
        .i_reset_n(I_RESET_N),
        .i_cause(causes[g]),
        .i_mask(masks[g]),
        .i_read_clear(read_clear[g]),
        .o_flags(flags[g]),
        .o_pending(pending[g])
      );
    end
  endgenerate

  // Converts an entry delay code to a cycle count at the clock rate.
  function automatic logic [31:0] delay_to_cycles(input logic [2:0] code);
    logic [63:0] prod;
    prod = 64'(DELAY_US[code]) * 64'(CLK_MHZ);
    if (code == 3'h7) begin
      prod = 64'(DELAY_MAX_CYCLES);
    end
    return prod[31:0];
  endfunction

  // ==========================================================================
  // Bus handling and register update
  // ==========================================================================
  // Read and write are served one at a time; a read is taken only when idle, so its
  // clear-on-read of a flag is a single cycle.
  always_comb begin
    logic hit;
    logic [7:0] wbyte;
    hit = 1'b0;
    wbyte = 8'h00;
    next_st = st;
    case (st.bus)
      NGM_IDLE: begin
        if (I_AWVALID && !st.aw_got) begin
          next_st.aw_got = 1'b1;
          next_st.waddr = I_AWADDR;
        end
        if (I_WVALID && !st.w_got) begin
          next_st.w_got = 1'b1;
          next_st.wdata = I_WDATA;
          next_st.wstrb = I_WSTRB;
        end
        if (st.aw_got && st.w_got) begin
          next_st.aw_got = 1'b0;
          next_st.w_got = 1'b0;
          next_st.bresp = RESP_SLVERR;
          wbyte = st.wdata[7:0];
          for (int i = 0; i < NUM_REGS; i++) begin
            if (wr_idx == REG_IDX[i]) begin
              next_st.bresp = RESP_OKAY;
              if (st.wstrb[0]) begin
                // Reserved bits keep their reset value; writable ones take the data.
                next_st.regs[i] = (REG_RST[i] & ~REG_WR[i]) | (wbyte & REG_WR[i]);
              end
            end
          end
          for (int j = 0; j < NUM_FLAGS; j++) begin
            if (wr_idx == FLAG_IDX[j]) begin
              next_st.bresp = RESP_OKAY; // Flags are read-only; the write is ignored.
            end
          end
          next_st.bus = NGM_WRESP;
        end else if (I_ARVALID) begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = RESP_SLVERR;
          for (int i = 0; i < NUM_REGS; i++) begin
            if (rd_idx == REG_IDX[i]) begin
              next_st.rdata = {24'h00_0000, st.regs[i]};
              next_st.rresp = RESP_OKAY;
              hit = 1'b1;
            end
          end
          for (int j = 0; j < NUM_FLAGS; j++) begin
            if (!hit && rd_idx == FLAG_IDX[j]) begin
              next_st.rdata = {24'h00_0000, flags[j]};
              next_st.rresp = RESP_OKAY;
            end
          end
          next_st.bus = NGM_RRESP;
        end
      end
      NGM_WRESP: begin
        if (I_BREADY) begin
          next_st.bus = NGM_IDLE;
        end
      end
      NGM_RRESP: begin
        if (I_RREADY) begin
          next_st.bus = NGM_IDLE;
        end
      end
      default: begin
        next_st.bus = NGM_IDLE;
      end
    endcase
    // Derived views of the configuration and the interrupt line, registered so their outputs come straight from flops.
    next_st.delay_cycles = delay_to_cycles(next_st.regs[REG_GATE][GATE_DELAY_LSB +: 3]);
    next_st.supply_valid = next_st.regs[REG_RAMP][HYS_LSB +: 4] >= HYS_FIRST_VALID;
    next_st.irq = |pending;
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      st <= '0;
      st.bus <= NGM_IDLE;
      for (int i = 0; i < NUM_REGS; i++) begin
        st.regs[i] <= REG_RST[i];
      end
      // The derived count matches the reset entry delay code from the first cycle.
      st.delay_cycles <= delay_to_cycles(RST_GATE_CFG[GATE_DELAY_LSB +: 3]);
      st.supply_valid <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Ready is high only in the idle cycle before an item is captured.
  assign O_AWREADY = (st.bus == NGM_IDLE) && !st.aw_got && I_RESET_N;
  assign O_WREADY = (st.bus == NGM_IDLE) && !st.w_got && I_RESET_N;
  assign O_ARREADY = (st.bus == NGM_IDLE) && !(st.aw_got && st.w_got) && I_RESET_N;
  assign O_BVALID = st.bus == NGM_WRESP;
  assign O_BRESP = st.bresp;
  assign O_RVALID = st.bus == NGM_RRESP;
  assign O_RDATA = st.rdata;
  assign O_RRESP = st.rresp;
  assign O_GATE_ENTRY_DELAY = st.regs[REG_GATE][GATE_DELAY_LSB +: 3];
  assign O_GATE_ENTRY_CYCLES = st.delay_cycles;
  assign O_GATE_LEVEL_THRESHOLD = st.regs[REG_GATE][GATE_THR_LSB +: 2];
  assign O_GATE_ENABLE = st.regs[REG_GATE][GATE_EN_BIT];
  assign O_GATE_VOLUME_RAMP_OFF = st.regs[REG_RAMP][RAMP_OFF_BIT];
  assign O_SUPPLY_SWITCH_HYSTERESIS = st.regs[REG_RAMP][HYS_LSB +: 4];
  assign O_SUPPLY_SWITCH_HYST_VALID = st.supply_valid;
  assign O_SUPPLY_SWITCH_THRESHOLD_MODE = st.regs[REG_THR][THR_MODE_BIT];
  assign O_SUPPLY_SWITCH_FIXED_THRESHOLD = st.regs[REG_THR][FIX_THR_LSB +: 5];
  assign O_PIN_WEAK_PULLDOWN = st.regs[REG_PD][PD_LSB +: 5];
  assign O_IRQ = st.irq;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_write_done;
    (st.bus == NGM_IDLE) && st.aw_got && st.w_got && st.wstrb[0];
  endsequence

  chk_gate_reset_val: assert property (@(posedge I_CLOCK) !I_RESET_N |=>
    O_GATE_ENABLE && O_GATE_ENTRY_DELAY == 3'h5 && O_GATE_LEVEL_THRESHOLD == 2'h3)
    else $error("gate reset values wrong");
  chk_ramp_reset_val: assert property (@(posedge I_CLOCK) !I_RESET_N |=>
    O_GATE_VOLUME_RAMP_OFF && O_SUPPLY_SWITCH_HYSTERESIS == 4'hD)
    else $error("ramp or hysteresis reset wrong");
  chk_thr_reset_val: assert property (@(posedge I_CLOCK) !I_RESET_N |=>
    O_SUPPLY_SWITCH_THRESHOLD_MODE && O_SUPPLY_SWITCH_FIXED_THRESHOLD == 5'h08 && O_PIN_WEAK_PULLDOWN == 5'h00)
    else $error("threshold or pull-down reset wrong");
  chk_mask_reset_val: assert property (@(posedge I_CLOCK) !I_RESET_N |=>
    st.regs[4] == 8'hFC && st.regs[5] == 8'hBB && st.regs[6] == 8'hDD && st.regs[7] == 8'hF6 && st.regs[8] == 8'h14)
    else $error("mask reset values wrong");
  chk_reserved_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
    s_write_done |=> ((st.regs[REG_GATE] & ~WR_GATE_CFG) == (RST_GATE_CFG & ~WR_GATE_CFG)))
    else $error("reserved gate bits changed");
  chk_gate_write: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
    s_write_done ##0 (wr_idx == IDX_GATE_CFG) |=> O_GATE_ENTRY_DELAY == $past(st.wdata[7:5]))
    else $error("entry delay not written");
  chk_delay_cycles: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
    (O_GATE_ENTRY_DELAY == 3'h0 && $stable(O_GATE_ENTRY_DELAY)) |-> O_GATE_ENTRY_CYCLES == 32'd100000)
    else $error("entry delay cycle count wrong");
  chk_irq_follows: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
    (|pending) ##1 (|pending) |-> O_IRQ)
    else $error("irq missing for unmasked flag");
  chk_read_latency: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
    (st.bus == NGM_IDLE && I_ARVALID && O_ARREADY) |=> O_RVALID)
    else $error("read answer late");
endmodule : ngm_regs

/* ngm_pkg.sv */
// Package for the noise gate, supply switch, pull-down and interrupt mask register bank.
// Assumes a single 250 MHz clock domain and an AXI4-Lite register port.
package ngm_pkg;
  // ==========================================================================
  // Register indices, sizes and response codes
  // ==========================================================================
  localparam logic [7:0] IDX_GATE_CFG = 8'h35;
  localparam logic [7:0] IDX_RAMP_HYS = 8'h36;
  localparam logic [7:0] IDX_SW_THR = 8'h37;
  localparam logic [7:0] IDX_PULLDOWN = 8'h38;
  localparam logic [7:0] IDX_MASK_BOH = 8'h3B;
  localparam logic [7:0] IDX_MASK_CRC = 8'h3C;
  localparam logic [7:0] IDX_MASK_CLK = 8'h3D;
  localparam logic [7:0] IDX_MASK_TMP = 8'h40;
  localparam logic [7:0] IDX_MASK_THB = 8'h41;
  localparam logic [7:0] IDX_FLAG_A = 8'h42;
  localparam logic [7:0] IDX_FLAG_B = 8'h43;
  localparam logic [7:0] IDX_FLAG_C = 8'h44;
  localparam logic [7:0] IDX_FLAG_D = 8'h47;
  localparam logic [7:0] IDX_FLAG_E = 8'h48;
  localparam int NUM_REGS = 9;
  localparam int NUM_FLAGS = 5;
  localparam int ADDR_W = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // Reset values and writable-bit masks
  // ==========================================================================
  localparam logic [7:0] RST_GATE_CFG = 8'hBD;
  localparam logic [7:0] RST_RAMP_HYS = 8'hAD;
  localparam logic [7:0] RST_SW_THR = 8'hA8;
  localparam logic [7:0] RST_PULLDOWN = 8'h00;
  localparam logic [7:0] RST_MASK_BOH = 8'hFC;
  localparam logic [7:0] RST_MASK_CRC = 8'hBB;
  localparam logic [7:0] RST_MASK_CLK = 8'hDD;
  localparam logic [7:0] RST_MASK_TMP = 8'hF6;
  localparam logic [7:0] RST_MASK_THB = 8'h14;
  localparam logic [7:0] WR_GATE_CFG = 8'hFC;
  localparam logic [7:0] WR_RAMP_HYS = 8'hEF;
  localparam logic [7:0] WR_SW_THR = 8'h9F;
  localparam logic [7:0] WR_PULLDOWN = 8'h7C;
  localparam logic [7:0] WR_MASK_BOH = 8'hC0;
  localparam logic [7:0] WR_MASK_CRC = 8'h41;
  localparam logic [7:0] WR_MASK_CLK = 8'h80;
  localparam logic [7:0] WR_MASK_TMP = 8'hF9;
  localparam logic [7:0] WR_MASK_THB = 8'hFC;
  // Flag bits that latch, per flag register: each bit with a mask bit in this bank except bit 2 of 48h.
  localparam logic [7:0] FL_USED_A = 8'hC0;
  localparam logic [7:0] FL_USED_B = 8'h41;
  localparam logic [7:0] FL_USED_C = 8'h80;
  localparam logic [7:0] FL_USED_D = 8'hF9;
  localparam logic [7:0] FL_USED_E = 8'hF8;
  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int GATE_DELAY_LSB = 5;
  localparam int GATE_THR_LSB = 3;
  localparam int GATE_EN_BIT = 2;
  localparam int RAMP_OFF_BIT = 5;
  localparam int HYS_LSB = 0;
  localparam int THR_MODE_BIT = 7;
  localparam int FIX_THR_LSB = 0;
  localparam int PD_LSB = 2;
  localparam logic [3:0] HYS_FIRST_VALID = 4'hA;
  // Entry delay times in microseconds for codes 0..7.
  localparam int DELAY_US [8] = '{400, 600, 800, 2000, 10000, 50000, 100000, 1000000};
  localparam int CLK_MHZ = 250;
  typedef enum logic [1:0] {NGM_IDLE = 2'b00, NGM_WRESP = 2'b01, NGM_RRESP = 2'b10} ngm_bus_t;
endpackage : ngm_pkg

/* ngm_flag.sv */
// One sticky interrupt flag register with a mask and a clear on read.
// Assumes cause pulses and the read strobe are on the same clock.
module ngm_flag
  import ngm_pkg::*;
#(
  parameter logic [7:0] USED = 8'hFF
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Causes, mask and clear.
  input wire logic [7:0] i_cause,
  input wire logic [7:0] i_mask,
  input wire logic i_read_clear,
  // Flag state.
  output logic [7:0] o_flags,
  output logic o_pending
);
  typedef struct packed {logic [7:0] flags;} ngm_flag_st_t;
  ngm_flag_st_t st;
  ngm_flag_st_t next_st;

  // A cause seen in the clearing cycle survives, since set wins over clear.
  always_comb begin
    next_st = st;
    if (i_read_clear) begin
      next_st.flags = 8'h00;
    end
    next_st.flags = next_st.flags | (i_cause & USED);
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_flags = st.flags;
  // Masked causes stay recorded and reach the pending line once their mask bit is cleared.
  assign o_pending = |(st.flags & ~i_mask);

  chk_set_beats_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    |(i_cause & USED) |=> |(st.flags & $past(i_cause & USED)))
    else $error("flag cause lost");
  chk_masked_quiet: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (((st.flags & ~i_mask) == 8'h00) && ((i_cause & USED & ~i_mask) == 8'h00)) ##1 $stable(i_mask)
    |-> !o_pending)
    else $error("masked flag raised pending");
endmodule : ngm_flag

/* ngm_regs_tb.sv */
// Self-checking testbench for the noise gate and interrupt mask register bank.
// Assumes the design files are compiled first and drives every port from this module.
module ngm_regs_tb
  import ngm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals and design instance
  // ==========================================================================
  localparam int MAXC = 1000;
  logic clk = 1'b0, rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic [7:0] cause [5] = '{default: 8'h00};
  logic awready, wready, bvalid, arready, rvalid, irq, en, ramp, hval, mode;
  logic [1:0] bresp, rresp, thr;
  logic [31:0] rdata, cycles;
  logic [2:0] dly;
  logic [3:0] hys;
  logic [4:0] fth, pd;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  ngm_regs #(.DELAY_MAX_CYCLES(MAXC)) i_dut (.I_CLOCK(clk), .I_RESET_N(rst_n),
    .I_AWVALID(awvalid), .I_AWADDR(awaddr), .O_AWREADY(awready), .I_WVALID(wvalid), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .O_WREADY(wready), .O_BVALID(bvalid), .O_BRESP(bresp), .I_BREADY(bready),
    .I_ARVALID(arvalid), .I_ARADDR(araddr), .O_ARREADY(arready), .O_RVALID(rvalid), .O_RDATA(rdata),
    .O_RRESP(rresp), .I_RREADY(rready), .I_CAUSE_A(cause[0]), .I_CAUSE_B(cause[1]), .I_CAUSE_C(cause[2]),
    .I_CAUSE_D(cause[3]), .I_CAUSE_E(cause[4]), .O_GATE_ENTRY_DELAY(dly), .O_GATE_ENTRY_CYCLES(cycles),
    .O_GATE_LEVEL_THRESHOLD(thr), .O_GATE_ENABLE(en), .O_GATE_VOLUME_RAMP_OFF(ramp),
    .O_SUPPLY_SWITCH_HYSTERESIS(hys), .O_SUPPLY_SWITCH_HYST_VALID(hval), .O_SUPPLY_SWITCH_THRESHOLD_MODE(mode),
    .O_SUPPLY_SWITCH_FIXED_THRESHOLD(fth), .O_PIN_WEAK_PULLDOWN(pd), .O_IRQ(irq));
  // All configuration outputs but the entry cycle count in one vector, so one compare covers those fields.
  wire [22:0] fields = {dly, thr, en, ramp, hys, hval, mode, fth, pd};
  // ==========================================================================
  // Clock, timeout and reporting
  // ==========================================================================
  // The clock toggles every half period of 2 ns.
  always #2 clk = ~clk;
  // A hung handshake would stall the run forever, so a cycle ceiling ends it.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================================
  // Register bus tasks
  // ==========================================================================
  // Handshakes are judged at the falling edge, where inputs and readies are settled,
  // and take effect at the next rising edge, where the signals are released.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s, output logic [1:0] resp);
    logic aw, w, b;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= s;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      resp = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    logic a, r;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      a = arvalid & arready;
      r = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (a) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ==========================================================================
  // Tests
  // ==========================================================================
  logic [7:0] idx [9] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h3B, 8'h3C, 8'h3D, 8'h40, 8'h41};
  logic [7:0] rsv [9] = '{8'hBD, 8'hAD, 8'hA8, 8'h00, 8'hFC, 8'hBB, 8'hDD, 8'hF6, 8'h14};
  logic [7:0] wrm [9] = '{8'hFC, 8'hEF, 8'h9F, 8'h7C, 8'hC0, 8'h41, 8'h80, 8'hF9, 8'hFC};
  // Entry delay in cycles at 250 MHz; the last code uses the shortened parameter.
  logic [31:0] dcyc [8] = '{100000, 150000, 200000, 500000, 2500000, 12500000, 25000000, MAXC};
  logic [7:0] fidx [5] = '{8'h42, 8'h43, 8'h44, 8'h47, 8'h48};
  logic [7:0] fbit [5] = '{8'h80, 8'h40, 8'h80, 8'h08, 8'h08};
  logic [31:0] d;
  logic [1:0] rs;
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("irq after reset", irq, 0);
    check("fields after reset", fields, {3'h5, 2'h3, 2'b11, 4'hD, 2'b11, 5'h08, 5'h00});
    check("cycles after reset", cycles, dcyc[5]);
    // Reset values, then all ones and all zeros against the writable bits.
    for (int i = 0; i < 9; i++) begin
      rd(idx[i], d, rs);
      check("reset value", d, {24'h0, rsv[i]});
    end
    for (int i = 0; i < 9; i++) begin
      wr(idx[i], 8'hFF, 4'hF, rs);
      check("write resp", rs, RESP_OKAY);
      rd(idx[i], d, rs);
      check("ones readback", d, {24'h0, rsv[i] | wrm[i]});
    end
    wait_cyc(2);
    check("fields all ones", fields, {3'h7, 2'h3, 2'b11, 4'hF, 2'b11, 5'h1F, 5'h1F});
    for (int i = 0; i < 9; i++) begin
      wr(idx[i], 8'h00, 4'hF, rs);
      rd(idx[i], d, rs);
      check("zeros readback", d, {24'h0, rsv[i] & ~wrm[i]});
    end
    wait_cyc(2);
    check("fields all zeros", fields, 23'h0);
    // Disabled byte lane leaves the register untouched.
    wr(8'h38, 8'hFF, 4'hE, rs);
    rd(8'h38, d, rs);
    check("strobe off", d, 32'h0);
    // Unmapped address answers with an error and reads zero.
    wr(8'h39, 8'hFF, 4'hF, rs);
    check("unmapped write resp", rs, RESP_SLVERR);
    rd(8'h39, d, rs);
    check("unmapped read resp", rs, RESP_SLVERR);
    check("unmapped read data", d, 32'h0);
    // Every entry delay code gives its cycle count.
    for (int c = 0; c < 8; c++) begin
      wr(8'h35, {c[2:0], 5'h1C}, 4'hF, rs);
      wait_cyc(3);
      check("entry cycles", cycles, dcyc[c]);
    end
    // Hysteresis codes below A are reserved.
    wr(8'h36, 8'h09, 4'hF, rs);
    wait_cyc(2);
    check("hys 9 valid", hval, 0);
    wr(8'h36, 8'h0A, 4'hF, rs);
    wait_cyc(2);
    check("hys A valid", hval, 1);
    // One cause bit per flag register raises the line only when unmasked, and is latched either way.
    for (int k = 0; k < 5; k++) begin
      for (int m = 0; m < 2; m++) begin
        wr(idx[k + 4], m ? 8'hFF : 8'h00, 4'hF, rs);
        @(posedge clk);
        cause[k] <= fbit[k];
        @(posedge clk);
        cause[k] <= 8'h00;
        wait_cyc(2);
        @(negedge clk);
        check("irq on cause", irq, m ? 1'b0 : 1'b1);
        rd(fidx[k], d, rs);
        check("flag latched", d, {24'h0, fbit[k]});
        wait_cyc(2);
        @(negedge clk);
        check("irq after read", irq, 0);
        rd(fidx[k], d, rs);
        check("flag cleared", d, 32'h0);
      end
    end
    // Flags ignore writes, and causes without a mask bit are not latched.
    wr(8'h42, 8'hFF, 4'hF, rs);
    @(posedge clk);
    cause[0] <= 8'h01;
    @(posedge clk);
    cause[0] <= 8'h00;
    wait_cyc(2);
    rd(8'h42, d, rs);
    check("flag read only", d, 32'h0);
    results();
  end
endmodule // ngm_regs_tb
